// [verilog/dsp_pkg.sv]
package dsp_pkg;

   // ************************************
   // Widths and reset values
   // ************************************
   localparam int WORD_W = 16;
   localparam int ACC_W = 40;
   localparam int PROD_W = 32;
   localparam int STACK_DEPTH = 4;
   localparam int SP_W = $clog2(STACK_DEPTH);
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
   localparam logic [15:0] LOOP_RESET = 16'h0000;

   // ************************************
   // Instruction fields
   // ************************************
   typedef enum logic [4:0] {
      op_nop, op_add, op_add_signed_short_imm, op_and, op_and_imm,
      op_and_unsigned_short_imm, op_compare_acc, op_invert_acc,
      op_decrement, op_decrement_mem, op_branch, op_call, op_return,
      op_loop_branch_nonzero, op_load_loop, op_count_leading_bits,
      op_zero, op_zero_reg, op_halt, op_add_product_pair,
      op_sub_product_pair, op_compare_product_pair, op_mac, op_shift
   } op_t;

   typedef enum logic [1:0] {
      src_reg, src_dmem, src_program_memory, src_long_immediate
   } src_t;

   typedef enum logic [2:0] {
      cond_always, cond_zero, cond_nonzero, cond_neg, cond_nonneg,
      cond_carry, cond_nocarry
   } cond_t;

   typedef enum logic [1:0] {
      st_run = 2'b01,
      st_halt = 2'b10
   } run_t;

   typedef struct packed {
      logic carry;
      logic neg;
      logic zero;
   } flags_t;

   typedef struct packed {
      op_t op;
      src_t src;
      cond_t cond;
      logic carry_mod;
      logic double_word_modifier;
      logic loop_sel;
      logic [2:0] reg_idx;
      logic [7:0] short_immediate;
      logic [15:0] long_immediate;
   } instr_t;

   // Instruction with operand words returned by the memories
   typedef struct packed {
      instr_t ins;
      logic [15:0] reg_word;
      logic [15:0] dmem_word;
      logic [15:0] pmem_word;
   } fetch_t;

   typedef struct packed {
      logic valid;
      logic [15:0] pc;
      fetch_t f;
   } pipe_t;

   typedef struct packed {
      run_t run;
      logic [15:0] pc;
      logic [15:0] prev_pc;
      logic fetch_req;
      logic pend;
      logic kill;
      pipe_t dec;
      logic [39:0] acc;
      logic [31:0] product;
      flags_t flags;
      logic [STACK_DEPTH-1:0][15:0] stack;
      logic [SP_W-1:0] sp;
      logic [1:0][15:0] loop_counter_pair;
      logic [5:0] lead_count;
      logic dmem_we;
      logic [15:0] dmem_wdata;
      logic reg_we;
      logic [2:0] reg_widx;
      logic [15:0] reg_wdata;
   } state_t;

endpackage

// [verilog/dsp_core_instruction_execute.sv]
// Notes on behaviour
// - Add with data memory operand adds fetched word into accumulator.
// - Add with program memory operand adds that word to the accumulator.
// - Add of short immediate sign-extends it before adding.
// - AND with data memory word changes only the accumulator high word.
// - AND with short immediate zero-extends it, result in high word only.
// - Branch loads target only when condition true, else runs on.
// - Call on true condition pushes return address then jumps to target.
// - Debug stop halts execution until resumed.
// - Leading-bit count gives the number of redundant sign bits.
// - One clear zeroes the accumulator, another zeroes a chosen register.
// - Compare subtracts to set flags and keeps the accumulator.
// - Invert complements accumulator bits 39:16 on condition, all 40 bits with double-word modifier.
// - Loop branch jumps while the selected loop counter is nonzero.
// - Accumulator decrement subtracts one only when condition holds.
// - Memory decrement reads, subtracts one, writes back on condition.
// - Accumulator is 40 bits, fed by multiplier and barrel shifter.
// - Arithmetic takes accumulator or product pair, 40-bit wide sums with carry out.
// - Fetch, decode and execute form a three-stage pipeline.
module dsp_core_instruction_execute (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Program fetch
   output logic [15:0] fetch_addr,
   output logic fetch_req,
   input wire logic fetch_valid,
   input wire dsp_pkg::fetch_t fetch_in,
   // Debug
   input wire logic resume,
   output logic halted,
   // Core state
   output logic [39:0] acc_out,
   output logic [31:0] product_out,
   output dsp_pkg::flags_t flags_out,
   output logic [5:0] lead_count,
   // Write back
   output logic dmem_we,
   output logic [15:0] dmem_wdata,
   output logic reg_we,
   output logic [2:0] reg_widx,
   output logic [15:0] reg_wdata
);

   // ************************************
   // State and helpers
   // ************************************
   dsp_pkg::state_t st_reg, st_next;
   dsp_pkg::pipe_t ex;
   logic ex_go, c_ok, fire, taken;
   logic [15:0] opnd;
   logic [39:0] opnd_al, prod_al, dm_al, pm_al, si_al, res;
   logic [40:0] cin, sum, diff, psum, pdiff;
   logic signed [7:0] sa;

   function automatic logic cond_ok(input dsp_pkg::cond_t c,
                                    input dsp_pkg::flags_t f);
      logic r;
      unique case (c)
         dsp_pkg::cond_always: r = 1'b1;
         dsp_pkg::cond_zero: r = f.zero;
         dsp_pkg::cond_nonzero: r = !f.zero;
         dsp_pkg::cond_neg: r = f.neg;
         dsp_pkg::cond_nonneg: r = !f.neg;
         dsp_pkg::cond_carry: r = f.carry;
         dsp_pkg::cond_nocarry: r = !f.carry;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic [5:0] lead_bits(input logic [39:0] a);
      logic [5:0] n;
      logic run;
      n = 6'h00;
      run = 1'b1;
      for (int i = 38; i >= 0; i--) begin
         if (run && a[i] == a[39]) begin
            n = n + 6'h01;
         end else begin
            run = 1'b0;
         end
      end
      return n;
   endfunction

   // ************************************
   // Operand selection and adders
   // ************************************
   always_comb begin
      ex = st_reg.dec;
      c_ok = cond_ok(ex.f.ins.cond, st_reg.flags);
      ex_go = ex.valid && st_reg.run == dsp_pkg::st_run;
      fire = ex_go && c_ok;
      sa = $signed(ex.f.ins.short_immediate);
      unique case (ex.f.ins.src)
         dsp_pkg::src_reg: opnd = ex.f.reg_word;
         dsp_pkg::src_dmem: opnd = ex.f.dmem_word;
         dsp_pkg::src_program_memory: opnd = ex.f.pmem_word;
         default: opnd = ex.f.ins.long_immediate;
      endcase
      if (ex.f.ins.op == dsp_pkg::op_add_signed_short_imm) begin
         opnd = {{8{sa[7]}}, ex.f.ins.short_immediate};
      end else if (ex.f.ins.op == dsp_pkg::op_and_unsigned_short_imm) begin
         opnd = {8'h00, ex.f.ins.short_immediate};
      end else if (ex.f.ins.op == dsp_pkg::op_and_imm) begin
         opnd = ex.f.ins.long_immediate;
      end
      dm_al = {{8{ex.f.dmem_word[15]}}, ex.f.dmem_word, 16'h0000};
      pm_al = {{8{ex.f.pmem_word[15]}}, ex.f.pmem_word, 16'h0000};
      si_al = {{16{sa[7]}}, ex.f.ins.short_immediate, 16'h0000};
      opnd_al = {{8{opnd[15]}}, opnd, 16'h0000};
      prod_al = {{8{st_reg.product[31]}}, st_reg.product};
      cin = {24'h00_0000, ex.f.ins.carry_mod & st_reg.flags.carry,
             16'h0000};
      sum = {1'b0, st_reg.acc} + {1'b0, opnd_al} + cin;
      diff = {1'b0, st_reg.acc} - {1'b0, opnd_al} - cin;
      psum = {1'b0, st_reg.acc} + {1'b0, prod_al};
      pdiff = {1'b0, st_reg.acc} - {1'b0, prod_al};
   end

   // ************************************
   // Pipeline and execute
   // ************************************
   always_comb begin
      st_next = st_reg;
      taken = 1'b0;
      res = st_reg.acc;
      st_next.dmem_we = 1'b0;
      st_next.reg_we = 1'b0;
      st_next.kill = 1'b0;
      st_next.pend = st_reg.fetch_req;
      // Fetch and decode stages
      if (st_reg.fetch_req) begin
         st_next.pc = st_reg.pc + 16'h0001;
         st_next.prev_pc = st_reg.pc;
      end
      st_next.dec.valid = fetch_valid && st_reg.pend && !st_reg.kill;
      st_next.dec.pc = st_reg.prev_pc;
      st_next.dec.f = fetch_in;
      if (st_reg.run == dsp_pkg::st_halt && resume) begin
         st_next.run = dsp_pkg::st_run;
      end
      // Execute stage
      if (fire) begin
         unique case (ex.f.ins.op)
            dsp_pkg::op_add, dsp_pkg::op_add_signed_short_imm: begin
               st_next.acc = sum[39:0];
               st_next.flags = '{sum[40], sum[39], sum[39:0] == 40'h0};
            end
            dsp_pkg::op_and, dsp_pkg::op_and_imm,
            dsp_pkg::op_and_unsigned_short_imm: begin
               st_next.acc[31:16] = st_reg.acc[31:16] & opnd;
               st_next.flags.neg = st_reg.acc[31] & opnd[15];
               st_next.flags.zero = (st_reg.acc[31:16] & opnd) == 16'h0000;
            end
            dsp_pkg::op_compare_acc: begin
               st_next.flags = '{diff[40], diff[39], diff[39:0] == 40'h0};
            end
            dsp_pkg::op_invert_acc: begin
               st_next.acc = ex.f.ins.double_word_modifier ? ~st_reg.acc :
                  {~st_reg.acc[39:16], st_reg.acc[15:0]};
            end
            dsp_pkg::op_decrement: begin
               res = ex.f.ins.double_word_modifier ?
                  st_reg.acc - 40'h00_0000_0001 :
                  st_reg.acc - 40'h00_0001_0000;
               st_next.acc = res;
               st_next.flags.neg = res[39];
               st_next.flags.zero = res == 40'h0;
            end
            dsp_pkg::op_decrement_mem: begin
               st_next.dmem_we = 1'b1;
               st_next.dmem_wdata = ex.f.dmem_word - 16'h0001;
               st_next.flags.zero = ex.f.dmem_word == 16'h0001;
               st_next.flags.neg = st_next.dmem_wdata[15];
            end
            dsp_pkg::op_branch: taken = 1'b1;
            dsp_pkg::op_call: begin
               st_next.stack[st_reg.sp] = ex.pc + 16'h0001;
               st_next.sp = st_reg.sp + 1'b1;
               taken = 1'b1;
            end
            dsp_pkg::op_return: begin
               st_next.sp = st_reg.sp - 1'b1;
            end
            dsp_pkg::op_loop_branch_nonzero: begin
               if (st_reg.loop_counter_pair[ex.f.ins.loop_sel] != 16'h0000)
               begin
                  st_next.loop_counter_pair[ex.f.ins.loop_sel] =
                     st_reg.loop_counter_pair[ex.f.ins.loop_sel] - 16'h0001;
                  taken = 1'b1;
               end
            end
            dsp_pkg::op_load_loop: begin
               st_next.loop_counter_pair[ex.f.ins.loop_sel] =
                  ex.f.ins.long_immediate;
            end
            dsp_pkg::op_count_leading_bits: begin
               st_next.lead_count = lead_bits(st_reg.acc);
            end
            dsp_pkg::op_zero: st_next.acc = dsp_pkg::ACC_RESET;
            dsp_pkg::op_zero_reg: begin
               st_next.reg_we = 1'b1;
               st_next.reg_widx = ex.f.ins.reg_idx;
               st_next.reg_wdata = 16'h0000;
            end
            dsp_pkg::op_halt: begin
               st_next.run = dsp_pkg::st_halt;
               st_next.pc = ex.pc + 16'h0001;
               st_next.dec.valid = 1'b0;
               st_next.kill = 1'b1;
            end
            dsp_pkg::op_add_product_pair: begin
               st_next.acc = psum[39:0];
               st_next.flags = '{psum[40], psum[39], psum[39:0] == 40'h0};
            end
            dsp_pkg::op_sub_product_pair: begin
               st_next.acc = pdiff[39:0];
               st_next.flags = '{pdiff[40], pdiff[39], pdiff[39:0] == 40'h0};
            end
            dsp_pkg::op_compare_product_pair: begin
               st_next.flags = '{pdiff[40], pdiff[39], pdiff[39:0] == 40'h0};
            end
            dsp_pkg::op_mac: begin
               st_next.product = 32'($signed(ex.f.reg_word) *
                                     $signed(ex.f.dmem_word));
            end
            dsp_pkg::op_shift: begin
               st_next.acc = sa[7] ? 40'($signed(st_reg.acc) >>> 8'(-sa)) :
                  st_reg.acc << sa;
            end
            default: ;
         endcase
      end
      if (fire && ex.f.ins.op == dsp_pkg::op_return) begin
         st_next.pc = st_reg.stack[st_reg.sp - 1'b1];
         st_next.dec.valid = 1'b0;
         st_next.kill = 1'b1;
      end
      if (taken) begin
         st_next.pc = ex.f.ins.long_immediate;
         st_next.dec.valid = 1'b0;
         st_next.kill = 1'b1;
      end
      st_next.fetch_req = st_next.run == dsp_pkg::st_run;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.run <= dsp_pkg::st_run;
         st_reg.pc <= dsp_pkg::PC_RESET;
         st_reg.acc <= dsp_pkg::ACC_RESET;
         st_reg.loop_counter_pair <= {2{dsp_pkg::LOOP_RESET}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign fetch_addr = st_reg.pc;
   assign fetch_req = st_reg.fetch_req;
   assign halted = st_reg.run[1];
   assign acc_out = st_reg.acc;
   assign product_out = st_reg.product;
   assign flags_out = st_reg.flags;
   assign lead_count = st_reg.lead_count;
   assign dmem_we = st_reg.dmem_we;
   assign dmem_wdata = st_reg.dmem_wdata;
   assign reg_we = st_reg.reg_we;
   assign reg_widx = st_reg.reg_widx;
   assign reg_wdata = st_reg.reg_wdata;

   // ************************************
   // Assertions
   // ************************************
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   sequence go_s(dsp_pkg::op_t o);
      fire && ex.f.ins.op == o;
   endsequence
   sequence redirect_s;
      !st_reg.dec.valid ##1 !st_reg.dec.valid;
   endsequence

   add_dmem_a: assert property (go_s(dsp_pkg::op_add) and
      ##0 (ex.f.ins.src == dsp_pkg::src_dmem && !ex.f.ins.carry_mod) |=>
      st_reg.acc == 40'($past(st_reg.acc) + $past(dm_al)))
      else $error("data memory add wrong");
   add_pmem_a: assert property (go_s(dsp_pkg::op_add) and
      ##0 (ex.f.ins.src == dsp_pkg::src_program_memory &&
      !ex.f.ins.carry_mod) |=>
      st_reg.acc == 40'($past(st_reg.acc) + $past(pm_al)))
      else $error("program memory add wrong");
   short_immediate_add_a: assert property (
      go_s(dsp_pkg::op_add_signed_short_imm) |=>
      st_reg.acc == 40'($past(st_reg.acc) + $past(si_al)))
      else $error("short immediate add wrong");
   and_high_a: assert property (go_s(dsp_pkg::op_and) and
      ##0 ex.f.ins.src == dsp_pkg::src_dmem |=>
      st_reg.acc[31:16] == ($past(st_reg.acc[31:16]) &
      $past(ex.f.dmem_word)) && $stable(st_reg.acc[39:32]) &&
      $stable(st_reg.acc[15:0])) else $error("memory AND wrong");
   and_uimm_a: assert property (
      go_s(dsp_pkg::op_and_unsigned_short_imm) |=>
      st_reg.acc[31:24] == 8'h00 && $stable(st_reg.acc[39:32]))
      else $error("unsigned AND not zero-extended");
   branch_a: assert property (go_s(dsp_pkg::op_branch) |=>
      st_reg.pc == $past(ex.f.ins.long_immediate) ##0 redirect_s)
      else $error("branch not taken");
   call_push_a: assert property (go_s(dsp_pkg::op_call) |=>
      st_reg.stack[$past(st_reg.sp)] == 16'($past(ex.pc) + 16'h0001) &&
      st_reg.pc == $past(ex.f.ins.long_immediate))
      else $error("call push wrong");
   halt_a: assert property (
      go_s(dsp_pkg::op_halt) ##1 !resume [*2] |->
      halted && !fetch_req) else $error("core not halted");
   zero_reg_a: assert property (go_s(dsp_pkg::op_zero_reg) |=>
      reg_we && reg_wdata == 16'h0000) else $error("register clear lost");
   compare_a: assert property (go_s(dsp_pkg::op_compare_acc) |=>
      $stable(st_reg.acc)) else $error("compare changed accumulator");
   cond_false_a: assert property (ex_go && !c_ok |=>
      $stable(st_reg.acc) && $stable(st_reg.flags) && !reg_we && !dmem_we)
      else $error("false condition changed state");

endmodule

// [bench/mem_model.sv]
module mem_model (
   // Clock
   input wire logic clk,
   // Fetch request
   input wire logic [15:0] fetch_addr,
   input wire logic fetch_req,
   // Reply
   output logic fetch_valid,
   output dsp_pkg::fetch_t fetch_in
);
   timeunit 1ns;
   timeprecision 1ps;

   dsp_pkg::fetch_t prog [0:63];

   initial begin
      fetch_valid = 1'b0;
      fetch_in = '0;
   end

   // Reply one cycle after each request, scrambled bus otherwise
   always @(posedge clk) begin
      fetch_valid <= fetch_req;
      if (fetch_req)
         fetch_in <= prog[fetch_addr[5:0]];
      else
         fetch_in <= ~fetch_in;
   end
endmodule

// [bench/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, srst, resume, fetch_req, fetch_valid, halted, dmem_we, reg_we;
   logic [15:0] fetch_addr, dmem_wdata, reg_wdata, last_dw, last_rw;
   logic [39:0] acc_out;
   logic [31:0] product_out;
   logic [5:0] lead_count;
   logic [2:0] reg_widx, last_ri;
   dsp_pkg::flags_t flags_out;
   dsp_pkg::fetch_t fetch_in;
   int n_errors, checks, n_dw, n_rw;

   dsp_core_instruction_execute u_dsp_core_instruction_execute (
      .clk(clk), .srst(srst), .fetch_addr(fetch_addr),
      .fetch_req(fetch_req), .fetch_valid(fetch_valid),
      .fetch_in(fetch_in), .resume(resume), .halted(halted),
      .acc_out(acc_out), .product_out(product_out),
      .flags_out(flags_out), .lead_count(lead_count),
      .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .reg_we(reg_we),
      .reg_widx(reg_widx), .reg_wdata(reg_wdata));

   mem_model u_mem_model (
      .clk(clk), .fetch_addr(fetch_addr), .fetch_req(fetch_req),
      .fetch_valid(fetch_valid), .fetch_in(fetch_in));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   // Write-back pulse monitor
   always @(posedge clk) begin
      if (srst) begin
         n_dw <= 0;
         n_rw <= 0;
      end else begin
         if (dmem_we === 1'b1) begin
            n_dw <= n_dw + 1;
            last_dw <= dmem_wdata;
         end
         if (reg_we === 1'b1) begin
            n_rw <= n_rw + 1;
            last_rw <= reg_wdata;
            last_ri <= reg_widx;
         end
      end
   end

   // ************************************
   // Helpers
   // ************************************
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic dsp_pkg::fetch_t mk(dsp_pkg::op_t op,
         dsp_pkg::src_t src, dsp_pkg::cond_t c, logic dw, logic [2:0] ri,
         logic [7:0] s, logic [15:0] l, logic [15:0] w);
      dsp_pkg::fetch_t f;
      f = '0;
      f.ins.op = op;
      f.ins.src = src;
      f.ins.cond = c;
      f.ins.double_word_modifier = dw;
      f.ins.loop_sel = ri[0];
      f.ins.reg_idx = ri;
      f.ins.short_immediate = s;
      f.ins.long_immediate = l;
      f.reg_word = (src == dsp_pkg::src_reg) ? w : 16'h7E7E;
      f.dmem_word = (src == dsp_pkg::src_dmem) ? w : 16'h6D6D;
      f.pmem_word = (src == dsp_pkg::src_program_memory) ? w : 16'h5C5C;
      return f;
   endfunction

   function automatic dsp_pkg::fetch_t li(dsp_pkg::op_t op, logic [15:0] l);
      return mk(op, dsp_pkg::src_long_immediate, dsp_pkg::cond_always,
         1'b0, 3'h0, 8'h00, l, 16'h0000);
   endfunction

   function automatic dsp_pkg::fetch_t co(dsp_pkg::op_t op,
         dsp_pkg::cond_t c, logic [15:0] l);
      return mk(op, dsp_pkg::src_long_immediate, c, 1'b0, 3'h0, 8'h00, l,
         16'h0000);
   endfunction

   function automatic dsp_pkg::fetch_t mo(dsp_pkg::op_t op,
         dsp_pkg::src_t src, logic [15:0] w);
      return mk(op, src, dsp_pkg::cond_always, 1'b0, 3'h0, 8'h00, 16'h0000,
         w);
   endfunction

   task automatic p(input int a, input dsp_pkg::fetch_t f);
      u_mem_model.prog[a] = f;
   endtask

   // Unused words add a marker so stray execution shows in the result
   task automatic clear_prog();
      for (int i = 0; i < 64; i++) begin
         p(i, li(dsp_pkg::op_add, 16'h0100));
      end
   endtask

   task automatic wait_halt();
      int i;
      i = 0;
      while (halted !== 1'b1 && i < 500) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk(40'(halted), 40'h1);
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic run();
      @(posedge clk);
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk(acc_out, 40'h0);
      chk(40'(halted), 40'h0);
      wait_halt();
   endtask

   // ************************************
   // Scenarios
   // ************************************
   task automatic t_add();
      clear_prog();
      p(0, mo(dsp_pkg::op_add, dsp_pkg::src_dmem, 16'h0100));
      p(1, mo(dsp_pkg::op_add, dsp_pkg::src_program_memory, 16'h0020));
      p(2, mk(dsp_pkg::op_add_signed_short_imm, dsp_pkg::src_reg,
         dsp_pkg::cond_always, 1'b0, 3'h0, 8'hFE, 16'h0000, 16'h0000));
      p(3, li(dsp_pkg::op_halt, 16'h0000));
      run();
      chk(acc_out, 40'h00_011E_0000);
      $display("test add done");
   endtask

   task automatic t_and();
      clear_prog();
      p(0, li(dsp_pkg::op_add, 16'hF0F0));
      p(1, mk(dsp_pkg::op_decrement, dsp_pkg::src_reg, dsp_pkg::cond_always,
         1'b1, 3'h0, 8'h00, 16'h0000, 16'h0000));
      p(2, mo(dsp_pkg::op_and, dsp_pkg::src_dmem, 16'h3C3C));
      p(3, mk(dsp_pkg::op_and_unsigned_short_imm, dsp_pkg::src_reg,
         dsp_pkg::cond_always, 1'b0, 3'h0, 8'hAF, 16'h0000, 16'h0000));
      p(4, li(dsp_pkg::op_and_imm, 16'hFF0C));
      p(5, li(dsp_pkg::op_halt, 16'h0000));
      run();
      chk(acc_out, 40'hFF_000C_FFFF);
      chk(40'({flags_out.neg, flags_out.zero}), 40'h0);
      $display("test and done");
   endtask

   task automatic t_flow();
      clear_prog();
      p(0, li(dsp_pkg::op_compare_acc, 16'h0000));
      p(1, co(dsp_pkg::op_call, dsp_pkg::cond_carry, 16'h000A));
      p(2, co(dsp_pkg::op_branch, dsp_pkg::cond_nonzero, 16'h000A));
      p(3, co(dsp_pkg::op_branch, dsp_pkg::cond_zero, 16'h0006));
      p(6, co(dsp_pkg::op_call, dsp_pkg::cond_nocarry, 16'h000C));
      p(12, li(dsp_pkg::op_add, 16'h0004));
      p(13, li(dsp_pkg::op_halt, 16'h0000));
      run();
      chk(acc_out, 40'h00_0004_0000);
      $display("test flow done");
   endtask

   task automatic t_loop();
      clear_prog();
      p(0, mk(dsp_pkg::op_load_loop, dsp_pkg::src_long_immediate,
         dsp_pkg::cond_always, 1'b0, 3'h0, 8'h00, 16'h0003, 16'h0000));
      p(1, mk(dsp_pkg::op_loop_branch_nonzero, dsp_pkg::src_long_immediate,
         dsp_pkg::cond_always, 1'b0, 3'h1, 8'h00, 16'h0014, 16'h0000));
      p(2, li(dsp_pkg::op_add, 16'h0001));
      p(3, mk(dsp_pkg::op_loop_branch_nonzero, dsp_pkg::src_long_immediate,
         dsp_pkg::cond_always, 1'b0, 3'h0, 8'h00, 16'h0002, 16'h0000));
      p(4, li(dsp_pkg::op_halt, 16'h0000));
      run();
      chk(acc_out, 40'h00_0004_0000);
      $display("test loop done");
   endtask

   task automatic t_cmp();
      clear_prog();
      p(0, li(dsp_pkg::op_add, 16'h0005));
      p(1, mo(dsp_pkg::op_compare_acc, dsp_pkg::src_program_memory, 16'h5));
      p(2, co(dsp_pkg::op_invert_acc, dsp_pkg::cond_nonzero, 16'h0000));
      p(3, co(dsp_pkg::op_decrement, dsp_pkg::cond_zero, 16'h0000));
      p(4, mo(dsp_pkg::op_compare_acc, dsp_pkg::src_program_memory, 16'h9));
      p(5, co(dsp_pkg::op_invert_acc, dsp_pkg::cond_neg, 16'h0000));
      p(6, li(dsp_pkg::op_compare_acc, 16'hFFFB));
      p(7, li(dsp_pkg::op_halt, 16'h0000));
      run();
      chk(acc_out, 40'hFF_FFFB_0000);
      chk(40'(flags_out), 40'h1);
      $display("test compare done");
   endtask

   task automatic t_mem();
      clear_prog();
      p(0, mk(dsp_pkg::op_decrement_mem, dsp_pkg::src_dmem,
         dsp_pkg::cond_carry, 1'b0, 3'h0, 8'h00, 16'h0000, 16'h0007));
      p(1, mo(dsp_pkg::op_decrement_mem, dsp_pkg::src_dmem, 16'h0001));
      p(2, mk(dsp_pkg::op_zero_reg, dsp_pkg::src_reg, dsp_pkg::cond_always,
         1'b0, 3'h5, 8'h00, 16'h0000, 16'h1234));
      p(3, li(dsp_pkg::op_add, 16'h0100));
      p(4, li(dsp_pkg::op_count_leading_bits, 16'h0000));
      p(5, li(dsp_pkg::op_zero, 16'h0000));
      p(6, li(dsp_pkg::op_halt, 16'h0000));
      run();
      chk(40'({n_dw[7:0], last_dw}), 40'h01_0000);
      chk(40'({n_rw[7:0], 1'b0, last_ri, last_rw}), 40'h01_5_0000);
      chk(40'(lead_count), 40'h0E);
      chk(acc_out, 40'h0);
      $display("test memory done");
   endtask

   task automatic t_halt();
      int i;
      clear_prog();
      p(0, li(dsp_pkg::op_add, 16'h0001));
      p(1, li(dsp_pkg::op_halt, 16'h0000));
      p(2, li(dsp_pkg::op_add, 16'h0002));
      p(3, li(dsp_pkg::op_halt, 16'h0000));
      run();
      repeat (5) begin
         @(posedge clk);
         #1;
         chk(40'({halted, fetch_req}), 40'h2);
      end
      chk(acc_out, 40'h00_0001_0000);
      @(posedge clk);
      resume <= 1'b1;
      @(posedge clk);
      resume <= 1'b0;
      i = 0;
      while (halted === 1'b1 && i < 20) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk(40'(halted), 40'h0);
      wait_halt();
      chk(acc_out, 40'h00_0003_0000);
      $display("test halt done");
   endtask

   task automatic t_prod();
      dsp_pkg::fetch_t f;
      clear_prog();
      f = li(dsp_pkg::op_add, 16'h0000);
      f.ins.carry_mod = 1'b1;
      p(0, li(dsp_pkg::op_call, 16'h0008));
      p(1, mk(dsp_pkg::op_shift, dsp_pkg::src_reg, dsp_pkg::cond_always,
         1'b0, 3'h0, 8'h04, 16'h0000, 16'h0000));
      p(2, li(dsp_pkg::op_compare_acc, 16'h0100));
      p(3, f);
      p(4, li(dsp_pkg::op_halt, 16'h0000));
      p(8, mo(dsp_pkg::op_mac, dsp_pkg::src_reg, 16'h0003));
      p(9, li(dsp_pkg::op_add_product_pair, 16'h0000));
      p(10, li(dsp_pkg::op_add_product_pair, 16'h0000));
      p(11, li(dsp_pkg::op_sub_product_pair, 16'h0000));
      p(12, li(dsp_pkg::op_return, 16'h0000));
      run();
      chk(40'(product_out), 40'h00_0001_4847);
      chk(acc_out, 40'h00_0015_8470);
      $display("test product done");
   endtask

   task automatic summarize();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end

   initial begin
      srst = 1'b1;
      resume = 1'b0;
      n_errors = 0;
      checks = 0;
      t_add();
      t_and();
      t_flow();
      t_loop();
      t_cmp();
      t_mem();
      t_halt();
      t_prod();
      summarize();
   end
endmodule
